// ===== pts_params.svh
// offsets, field positions, reset values and timing figures of the smoothing filter
`ifndef PTS_PARAMS_SVH
`define PTS_PARAMS_SVH
`define PTS_ADDR_W        8
`define PTS_DATA_W        32
`define PTS_OFF_CTRL      8'h00
`define PTS_OFF_SAMPLE    8'h04
`define PTS_OFF_RECOVERY  8'h08
`define PTS_OFF_GAIN      8'h0C
`define PTS_OFF_CYCLE     8'h10
`define PTS_OFF_OUTPUT    8'h14
`define PTS_OFF_STATUS    8'h18
`define PTS_OFF_MASK      8'h1C
`define PTS_CTRL_EN_BIT   0
`define PTS_ST_STEP_BIT   0
`define PTS_ST_OVF_BIT    1
`define PTS_ST_W          2
`define PTS_CYCLE_RESET   16'h0001
`define PTS_CLK_NS        20
`define PTS_MS_NS         1000000
`define PTS_TICK_CYCLES   (`PTS_MS_NS / `PTS_CLK_NS)
`define PTS_TG_MS_UNIT    100
`define PTS_TG_SHORT      10
`define PTS_TA_SHORT_MS   10
`define PTS_GAIN_UNITY    100
`define PTS_TA_W          18
`define PTS_NUM_W         51
`define PTS_DEN_W         30
`define PTS_CNT_W         6
`endif

// ===== pts_pkg.sv
// types shared by the smoothing filter modules
package pts_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DIV  = 2'b10
	} pts_state_type;
endpackage

// ===== pts_divider.sv
// iterative unsigned divider, one quotient bit per clock
`include "pts_params.svh"
module pts_divider #(
	parameter int NUM_W = `PTS_NUM_W,
	parameter int DEN_W = `PTS_DEN_W
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             start,
	input  wire logic [NUM_W-1:0] num,
	input  wire logic [DEN_W-1:0] den,
	output logic                  done,
	output logic      [NUM_W-1:0] quot
);
	logic [NUM_W-1:0]      num_reg, num_next, quot_reg, quot_next;
	logic [DEN_W-1:0]      den_reg, den_next;
	logic [DEN_W:0]        rem_reg, rem_next;
	logic [`PTS_CNT_W-1:0] cnt_reg, cnt_next;
	logic                  busy_reg, busy_next, done_reg, done_next;
	logic [DEN_W:0]        rem_sh;

	always_comb begin
		num_next  = num_reg;
		den_next  = den_reg;
		quot_next = quot_reg;
		rem_next  = rem_reg;
		cnt_next  = cnt_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		rem_sh    = {rem_reg[DEN_W-1:0], num_reg[NUM_W-1]};
		if (start && !busy_reg) begin
			num_next  = num;
			den_next  = den;
			rem_next  = '0;
			quot_next = '0;
			cnt_next  = `PTS_CNT_W'(NUM_W - 1);
			busy_next = 1'b1;
		end else if (busy_reg) begin
			num_next = {num_reg[NUM_W-2:0], 1'b0};
			if (rem_sh >= {1'b0, den_reg}) begin
				rem_next  = rem_sh - {1'b0, den_reg};
				quot_next = {quot_reg[NUM_W-2:0], 1'b1};
			end else begin
				rem_next  = rem_sh;
				quot_next = {quot_reg[NUM_W-2:0], 1'b0};
			end
			cnt_next = cnt_reg - 1'b1;
			if (cnt_reg == '0) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			num_reg  <= '0;
			den_reg  <= '0;
			quot_reg <= '0;
			rem_reg  <= '0;
			cnt_reg  <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			num_reg  <= num_next;
			den_reg  <= den_next;
			quot_reg <= quot_next;
			rem_reg  <= rem_next;
			cnt_reg  <= cnt_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign done = done_reg;
	assign quot = quot_reg;
endmodule

// ===== pts_scan_timer.sv
// millisecond base and host-cycle-aligned scan step generator
`include "pts_params.svh"
module pts_scan_timer #(
	parameter int TICK_CYCLES = `PTS_TICK_CYCLES,
	parameter int TA_W        = `PTS_TA_W
) (
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            run,
	input  wire logic [15:0]     cycle_ms,
	input  wire logic [TA_W-1:0] ta_ms,
	output logic                 step,
	output logic      [TA_W-1:0] ta_eff
);
	logic [31:0]     tick_reg, tick_next;
	logic [15:0]     cyc_reg, cyc_next;
	logic [TA_W-1:0] acc_reg, acc_next, eff_reg, eff_next, acc_sum;
	logic            step_reg, step_next;
	logic [15:0]     cyc_len;

	always_comb begin
		tick_next = tick_reg;
		cyc_next  = cyc_reg;
		acc_next  = acc_reg;
		eff_next  = eff_reg;
		step_next = 1'b0;
		// a zero cycle time would never end a host cycle
		cyc_len   = (cycle_ms == 16'h0000) ? 16'h0001 : cycle_ms;
		acc_sum   = acc_reg + TA_W'(cyc_len);
		if (!run) begin
			tick_next = '0;
			cyc_next  = '0;
			acc_next  = '0;
		end else if (tick_reg == 32'(TICK_CYCLES - 1)) begin
			tick_next = '0;
			if (cyc_reg >= cyc_len - 16'h0001) begin
				cyc_next = '0;
				// scan only ends on a host cycle boundary, so the interval may grow
				if (acc_sum >= ta_ms) begin
					acc_next  = '0;
					eff_next  = acc_sum;
					step_next = 1'b1;
				end else begin
					acc_next = acc_sum;
				end
			end else begin
				cyc_next = cyc_reg + 16'h0001;
			end
		end else begin
			tick_next = tick_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_reg <= '0;
			cyc_reg  <= '0;
			acc_reg  <= '0;
			eff_reg  <= '0;
			step_reg <= 1'b0;
		end else begin
			tick_reg <= tick_next;
			cyc_reg  <= cyc_next;
			acc_reg  <= acc_next;
			eff_reg  <= eff_next;
			step_reg <= step_next;
		end
	end

	assign step   = step_reg;
	assign ta_eff = eff_reg;
endmodule

// ===== pts_smoother.sv
// first-order smoothing filter with register port and interrupt
`include "pts_params.svh"
module pts_smoother #(
	parameter int TICK_CYCLES = `PTS_TICK_CYCLES
) (
	input  wire logic                   REF_CLK,
	input  wire logic                   RST_B,
	input  wire logic [`PTS_ADDR_W-1:0] ADDR,
	input  wire logic [`PTS_DATA_W-1:0] WR_DATA,
	input  wire logic                   WR_STB,
	input  wire logic                   RD_STB,
	output logic      [`PTS_DATA_W-1:0] RD_DATA,
	output logic      [15:0]            SMOOTHED_OUT,
	output logic                        RANGE_OVERFLOW_FLAG,
	output logic                        IRQ
);
	localparam int TA_W  = `PTS_TA_W;
	localparam int NUM_W = `PTS_NUM_W;
	localparam int DEN_W = `PTS_DEN_W;

	logic rst_meta_reg, rst_sync_reg;
	logic rst_n;

	// asynchronous assert, synchronous release
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	function automatic logic [TA_W-1:0] scan_ms(input logic [15:0] tg);
		// recovery in 100 ms units: tg/100 in ms is tg itself
		scan_ms = (tg <= 16'(`PTS_TG_SHORT)) ? TA_W'(`PTS_TA_SHORT_MS) : TA_W'(tg);
	endfunction

	function automatic logic [15:0] sat16(input logic signed [NUM_W+1:0] v);
		if (v > 32767)
			sat16 = 16'h7FFF;
		else if (v < -32768)
			sat16 = 16'h8000;
		else
			sat16 = v[15:0];
	endfunction

	logic                     en_reg, en_next;
	logic signed [15:0]       sample_reg, sample_next;
	logic [15:0]              tg_reg, tg_next, gain_reg, gain_next, cyc_reg, cyc_next;
	logic [`PTS_ST_W-1:0]     stat_reg, stat_next, mask_reg, mask_next;
	logic [`PTS_DATA_W-1:0]   rd_reg, rd_next;
	logic                     irq_reg, irq_next;
	logic [`PTS_ST_W-1:0]     ev;
	logic [`PTS_ST_W-1:0]     clr;

	pts_pkg::pts_state_type   state_reg, state_next;
	logic signed [15:0]       y_reg, y_next;
	logic                     ovf_reg, ovf_next;
	logic                     neg_reg, neg_next;
	logic                     step_ev, ovf_ev;

	logic                     scan_step;
	logic [TA_W-1:0]          ta_eff;
	logic                     div_start, div_done;
	logic [NUM_W-1:0]         div_num, div_quot;
	logic [DEN_W-1:0]         div_den, tg_den;
	logic signed [16:0]       diff;
	logic [16:0]              mag;
	logic signed [NUM_W+1:0]  sum;

	pts_scan_timer #(
		.TICK_CYCLES (TICK_CYCLES),
		.TA_W        (TA_W)
	) u_timer (
		.clk      (REF_CLK),
		.rst_n    (rst_n),
		.run      (state_reg != pts_pkg::ST_IDLE),
		.cycle_ms (cyc_reg),
		.ta_ms    (scan_ms(tg_reg)),
		.step     (scan_step),
		.ta_eff   (ta_eff)
	);

	pts_divider #(
		.NUM_W (NUM_W),
		.DEN_W (DEN_W)
	) u_div (
		.clk   (REF_CLK),
		.rst_n (rst_n),
		.start (div_start),
		.num   (div_num),
		.den   (div_den),
		.done  (div_done),
		.quot  (div_quot)
	);

	// delta = ta * gain * (x - y) / (tg_ms * 100)
	always_comb begin
		diff      = 17'(sample_reg) - 17'(y_reg);
		mag       = diff[16] ? 17'(-diff) : diff;
		div_num   = NUM_W'(ta_eff) * NUM_W'(gain_reg) * NUM_W'(mag);
		tg_den    = DEN_W'(tg_reg) * DEN_W'(`PTS_TG_MS_UNIT * `PTS_GAIN_UNITY);
		// ratio capped at one: a zero recovery time would otherwise divide by zero
		div_den   = (tg_den > DEN_W'(ta_eff)) ? tg_den : DEN_W'(ta_eff);
		div_start = (state_reg == pts_pkg::ST_WAIT) && scan_step;
	end

	// filter sequence
	always_comb begin
		state_next = state_reg;
		y_next     = y_reg;
		ovf_next   = ovf_reg;
		neg_next   = neg_reg;
		step_ev    = 1'b0;
		ovf_ev     = 1'b0;
		sum        = neg_reg ? ((NUM_W+2)'(y_reg) - $signed({2'b00, div_quot}))
		                     : ((NUM_W+2)'(y_reg) + $signed({2'b00, div_quot}));
		if (!en_reg) begin
			state_next = pts_pkg::ST_IDLE;
			y_next     = '0;
			ovf_next   = 1'b0;
		end else begin
			case (state_reg)
				pts_pkg::ST_IDLE: begin
					// first pass after start or enable: no ramp from zero
					y_next     = sample_reg;
					ovf_next   = 1'b0;
					state_next = pts_pkg::ST_WAIT;
				end
				pts_pkg::ST_WAIT: begin
					if (scan_step) begin
						neg_next   = diff[16];
						state_next = pts_pkg::ST_DIV;
					end
				end
				pts_pkg::ST_DIV: begin
					if (div_done) begin
						// accumulated first-order step gives the exponential rise
						y_next     = sat16(sum);
						ovf_next   = (sum > 32767) || (sum < -32768);
						ovf_ev     = ovf_next;
						step_ev    = 1'b1;
						state_next = pts_pkg::ST_WAIT;
					end
				end
				default: begin
					state_next = pts_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// register port and interrupt
	always_comb begin
		en_next     = en_reg;
		sample_next = sample_reg;
		tg_next     = tg_reg;
		gain_next   = gain_reg;
		cyc_next    = cyc_reg;
		mask_next   = mask_reg;
		clr         = '0;
		rd_next     = '0;
		ev          = '0;
		ev[`PTS_ST_STEP_BIT] = step_ev;
		ev[`PTS_ST_OVF_BIT]  = ovf_ev;
		if (WR_STB) begin
			case (ADDR)
				`PTS_OFF_CTRL:     en_next     = WR_DATA[`PTS_CTRL_EN_BIT];
				`PTS_OFF_SAMPLE:   sample_next = WR_DATA[15:0];
				`PTS_OFF_RECOVERY: tg_next     = WR_DATA[15:0];
				`PTS_OFF_GAIN:     gain_next   = WR_DATA[15:0];
				`PTS_OFF_CYCLE:    cyc_next    = WR_DATA[15:0];
				`PTS_OFF_STATUS:   clr         = WR_DATA[`PTS_ST_W-1:0];
				`PTS_OFF_MASK:     mask_next   = WR_DATA[`PTS_ST_W-1:0];
				default:           ;
			endcase
		end
		if (RD_STB) begin
			case (ADDR)
				`PTS_OFF_CTRL:     rd_next = 32'(en_reg);
				`PTS_OFF_SAMPLE:   rd_next = 32'(sample_reg);
				`PTS_OFF_RECOVERY: rd_next = 32'(tg_reg);
				`PTS_OFF_GAIN:     rd_next = 32'(gain_reg);
				`PTS_OFF_CYCLE:    rd_next = 32'(cyc_reg);
				`PTS_OFF_OUTPUT:   rd_next = 32'(y_reg);
				`PTS_OFF_STATUS:   rd_next = 32'(stat_reg);
				`PTS_OFF_MASK:     rd_next = 32'(mask_reg);
				default:           rd_next = '0;
			endcase
		end
		// a new event beats a clear in the same cycle
		stat_next = (stat_reg & ~clr) | ev;
		irq_next  = |(stat_next & mask_next);
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			en_reg     <= 1'b0;
			sample_reg <= '0;
			tg_reg     <= '0;
			gain_reg   <= 16'(`PTS_GAIN_UNITY);
			cyc_reg    <= `PTS_CYCLE_RESET;
			mask_reg   <= '0;
			stat_reg   <= '0;
			rd_reg     <= '0;
			irq_reg    <= 1'b0;
			state_reg  <= pts_pkg::ST_IDLE;
			y_reg      <= '0;
			ovf_reg    <= 1'b0;
			neg_reg    <= 1'b0;
		end else begin
			en_reg     <= en_next;
			sample_reg <= sample_next;
			tg_reg     <= tg_next;
			gain_reg   <= gain_next;
			cyc_reg    <= cyc_next;
			mask_reg   <= mask_next;
			stat_reg   <= stat_next;
			rd_reg     <= rd_next;
			irq_reg    <= irq_next;
			state_reg  <= state_next;
			y_reg      <= y_next;
			ovf_reg    <= ovf_next;
			neg_reg    <= neg_next;
		end
	end

	assign RD_DATA             = rd_reg;
	assign SMOOTHED_OUT        = y_reg;
	assign RANGE_OVERFLOW_FLAG = ovf_reg;
	assign IRQ                 = irq_reg;
endmodule

// ===== pts_checker.sv
// port assertions for the smoothing filter
module pts_checker (
	input wire logic        REF_CLK,
	input wire logic        RST_B,
	input wire logic [7:0]  ADDR,
	input wire logic [31:0] WR_DATA,
	input wire logic        WR_STB,
	input wire logic        RD_STB,
	input wire logic [31:0] RD_DATA,
	input wire logic [15:0] SMOOTHED_OUT,
	input wire logic        RANGE_OVERFLOW_FLAG,
	input wire logic        IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        en_reg;
	logic        en_next;
	logic [15:0] smp_reg;
	logic [15:0] smp_next;
	logic [15:0] gain_reg;
	logic [15:0] gain_next;
	logic [1:0]  mask_reg;
	logic [1:0]  mask_next;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	// shadow of the enable, sample, gain and mask registers, so reads and preload can be predicted
	always_comb begin
		en_next = en_reg;
		smp_next = smp_reg;
		gain_next = gain_reg;
		mask_next = mask_reg;
		if (WR_STB) begin
			case (ADDR)
				8'h00: en_next = WR_DATA[0];
				8'h04: smp_next = WR_DATA[15:0];
				8'h0C: gain_next = WR_DATA[15:0];
				8'h1C: mask_next = WR_DATA[1:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			en_reg <= 1'b0;
			smp_reg <= 16'h0000;
			gain_reg <= 16'h0064;
			mask_reg <= 2'h0;
		end else begin
			en_reg <= en_next;
			smp_reg <= smp_next;
			gain_reg <= gain_next;
			mask_reg <= mask_next;
		end
	end
	rd_idle_a: assert property (!RD_STB |=> RD_DATA == 32'h00000000)
		else $error("read data not zero outside a read");
	out_read_a: assert property (RD_STB && ADDR == 8'h14 |=>
		RD_DATA == {{16{$past(SMOOTHED_OUT[15])}}, $past(SMOOTHED_OUT)})
		else $error("output read wrong");
	unmapped_rd_a: assert property (RD_STB && (ADDR > 8'h1C || ADDR[1:0] != 2'h0)
		|=> RD_DATA == 32'h00000000) else $error("unmapped read not zero");
	gain_read_a: assert property (RD_STB && ADDR == 8'h0C |=>
		RD_DATA == {16'h0000, gain_reg})
		else $error("gain read wrong");
	// the interrupt flop was loaded with the mask that stands now, so no delay here
	mask_quiet_a: assert property (mask_reg == 2'h0 |-> !IRQ)
		else $error("interrupt with all masked");
	disable_zero_a: assert property (
		WR_STB && ADDR == 8'h00 && !WR_DATA[0] |->
		##2 (SMOOTHED_OUT == 16'h0000 && !RANGE_OVERFLOW_FLAG))
		else $error("disable did not clear output");
	// preload takes the sample held when enable landed, not one written just after
	start_preload_a: assert property (
		WR_STB && ADDR == 8'h00 && WR_DATA[0] && !en_reg |-> ##2 SMOOTHED_OUT == $past(smp_reg))
		else $error("output not preloaded");
	ovf_clamp_a: assert property (RANGE_OVERFLOW_FLAG |->
		SMOOTHED_OUT == 16'h7FFF || SMOOTHED_OUT == 16'h8000)
		else $error("overflow without clamp");
endmodule
bind pts_smoother pts_checker u_chk (
	.REF_CLK            (REF_CLK),
	.RST_B              (RST_B),
	.ADDR               (ADDR),
	.WR_DATA            (WR_DATA),
	.WR_STB             (WR_STB),
	.RD_STB             (RD_STB),
	.RD_DATA            (RD_DATA),
	.SMOOTHED_OUT       (SMOOTHED_OUT),
	.RANGE_OVERFLOW_FLAG(RANGE_OVERFLOW_FLAG),
	.IRQ                (IRQ)
);

// ===== pts_host_model.sv
// cyclic controller program model driving the register port
module pts_host_model (
	input wire logic        clk,
	output logic     [7:0]  addr,
	output logic     [31:0] wdata,
	output logic            wr,
	output logic            rd,
	input wire logic [31:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr = 8'h00;
		wdata = 32'h00000000;
		wr = 1'b0;
		rd = 1'b0;
	end
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe, so they are taken mid-cycle
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
endmodule

// ===== tb_top.sv
// self-checking bench for the smoothing filter
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// 16 clocks per ms keeps a 10 ms step longer than the 53-cycle update
	localparam int TICK = 16;
	logic        REF_CLK = 1'b0;
	logic        RST_B = 1'b0;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic [15:0] out_w;
	logic        ovf_w;
	logic        irq_w;
	int          bad_count = 0;
	int          total_checks = 0;
	int          n;
	int          i;
	// a recovery below one second still scans every 10 ms
	int          rows [4][3] = '{'{10, 1, 10 * TICK}, '{20, 1, 20 * TICK},
	                             '{10, 3, 12 * TICK}, '{5, 1, 10 * TICK}};
	logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
	logic [31:0] rv [9] = '{0, 0, 0, 32'h64, 32'h1, 0, 0, 0, 0};
	always #10 REF_CLK = ~REF_CLK;
	pts_smoother #(.TICK_CYCLES(TICK)) dut (
		.REF_CLK            (REF_CLK),
		.RST_B              (RST_B),
		.ADDR               (addr),
		.WR_DATA            (wdata),
		.WR_STB             (wr),
		.RD_STB             (rd),
		.RD_DATA            (rdata),
		.SMOOTHED_OUT       (out_w),
		.RANGE_OVERFLOW_FLAG(ovf_w),
		.IRQ                (irq_w)
	);
	pts_host_model host (
		.clk  (REF_CLK),
		.addr (addr),
		.wdata(wdata),
		.wr   (wr),
		.rd   (rd),
		.rdata(rdata)
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		host.rd_reg(a, d);
		chk(d, exp, "register read");
	endtask
	// wait for a step, check and clear status, then keep clear of the update window
	task automatic step_wait(input logic [31:0] st);
		int k;
		for (k = 0; k < 800 && irq_w !== 1'b1; k++) @(negedge REF_CLK);
		chk(irq_w, 1'b1, "step interrupt");
		rchk(8'h18, st);
		host.wr_reg(8'h18, 32'h3);
		repeat (2) @(negedge REF_CLK);
		chk(irq_w, 1'b0, "interrupt cleared");
		repeat (60) @(negedge REF_CLK);
	endtask
	task automatic meas(output int cnt);
		logic [15:0] v;
		int k;
		v = out_w;
		for (k = 0; k < 900 && out_w === v; k++) @(negedge REF_CLK);
		v = out_w;
		cnt = 0;
		while (cnt < 900 && out_w === v) begin
			@(negedge REF_CLK);
			cnt++;
		end
	endtask
	task automatic print_verdict();
		if (bad_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge REF_CLK);
		bad_count++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge REF_CLK);
		RST_B <= 1'b1;
		repeat (3) @(posedge REF_CLK);
		for (i = 0; i < 9; i++) rchk(ra[i], rv[i]);
		host.wr_reg(8'h14, 32'h5);
		host.wr_reg(8'h20, 32'h5);
		rchk(8'h14, 32'h0);
		host.wr_reg(8'h04, 32'd1000);
		host.wr_reg(8'h08, 32'd10);
		host.wr_reg(8'h1C, 32'h1);
		host.wr_reg(8'h00, 32'h1);
		repeat (3) @(negedge REF_CLK);
		chk(out_w, 16'd1000, "preload");
		host.wr_reg(8'h04, 32'd2000);
		step_wait(32'h1);
		chk(out_w, 16'd1010, "first step");
		host.wr_reg(8'h08, 32'd0);
		host.wr_reg(8'h0C, 32'd1000);
		host.wr_reg(8'h04, 32'h7FFF);
		step_wait(32'h3);
		chk({ovf_w, out_w}, 17'h17FFF, "high clamp");
		step_wait(32'h1);
		chk({ovf_w, out_w}, 17'h07FFF, "flag cleared");
		host.wr_reg(8'h04, 32'hFFFF8000);
		step_wait(32'h3);
		chk({ovf_w, out_w}, 17'h18000, "low clamp");
		rchk(8'h14, 32'hFFFF8000);
		host.wr_reg(8'h00, 32'h0);
		repeat (2) @(negedge REF_CLK);
		chk({ovf_w, out_w}, 17'h00000, "disabled");
		// steps below keep setting status while the mask holds the interrupt low
		host.wr_reg(8'h1C, 32'h0);
		for (i = 0; i < 4; i++) begin
			host.wr_reg(8'h00, 32'h0);
			host.wr_reg(8'h08, rows[i][0]);
			host.wr_reg(8'h10, rows[i][1]);
			host.wr_reg(8'h04, 32'h0);
			host.wr_reg(8'h0C, 32'd100);
			host.wr_reg(8'h00, 32'h1);
			repeat (3) @(negedge REF_CLK);
			host.wr_reg(8'h04, 32'd30000);
			meas(n);
			chk(n, rows[i][2], "scan period");
		end
		chk(irq_w, 1'b0, "masked interrupt");
		rchk(8'h18, 32'h1);
		print_verdict();
	end
endmodule
